// file: ccsf_peer.sv
// Peer controller model that sends master words over the link
`default_nettype none
module ccsf_peer (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Send request from the bench
   input wire logic go_i,
   input wire logic [4:0] src_i,
   input wire logic [15:0] word_i,
   input wire logic [7:0] lag_i,
   // Link towards the block
   output ccsf_pkg::ccsf_link_t link_o,
   output logic busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_reg;
   ccsf_pkg::ccsf_link_t hold_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 8'h00;
         busy_o <= 1'b0;
         link_o <= '0;
      end else if (go_i && !busy_o) begin
         // Five-bit address keeps the ring at 32 nodes
         hold_reg <= '{1'b1, src_i, word_i};
         cnt_reg <= lag_i;
         busy_o <= 1'b1;
         link_o.valid <= 1'b0;
      end else if (busy_o && cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end else if (busy_o) begin
         link_o <= hold_reg;
         busy_o <= 1'b0;
      end else begin
         // Idle link shows junk, so a stale word cannot pass
         link_o <= '{1'b0, ~link_o.src, ~link_o.word};
      end
   end
endmodule : ccsf_peer
`default_nettype wire

// file: ccsf_pkg.sv
// Package with constants and types of the cascade setpoint follower
`default_nettype none
package ccsf_pkg;
   // Clock and timing
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned EDIT_TIMEOUT_S = 60;
   localparam int unsigned EDIT_TIMEOUT_CYC = EDIT_TIMEOUT_S * CLK_HZ;
   localparam int unsigned FILT_TICK_MS = 100;
   localparam int unsigned FILT_TICK_CYC = CLK_HZ / 1000 * FILT_TICK_MS;
   localparam int unsigned LINK_LAG_MS = 70;
   localparam int unsigned LINK_MAX_NODES = 32;
   // Register byte offsets
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_EDIT = 8'h04;
   localparam logic [7:0] OFS_CONFIRM = 8'h08;
   localparam logic [7:0] OFS_BIAS = 8'h0C;
   localparam logic [7:0] OFS_FILTER = 8'h10;
   localparam logic [7:0] OFS_RATIO = 8'h14;
   localparam logic [7:0] OFS_SCALE = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   // Field positions
   localparam int CFG_TYPE_LSB = 0;
   localparam int CFG_CHAN_LSB = 8;
   localparam int SCALE_HI_LSB = 16;
   // Value ranges and reset values
   localparam logic [15:0] RATIO_RST = 16'h03E8;
   localparam logic [15:0] RATIO_MIN = 16'h0001;
   localparam logic [15:0] RATIO_MAX = 16'h270F;
   localparam logic [15:0] FILT_OFF = 16'h0000;
   localparam logic [15:0] FILT_MIN = 16'h0001;
   localparam logic [15:0] FILT_MAX = 16'h03E8;
   localparam logic [15:0] FIXED_ONE = 16'h03E8;
   localparam logic [15:0] MV_FULL = 16'h03E8;
   localparam logic [15:0] SCALE_LO_RST = 16'h0000;
   localparam logic [15:0] SCALE_HI_RST = 16'h03E8;
   localparam logic [4:0] CHAN_RST = 5'h00;
   // External input type codes
   typedef enum logic [1:0] {
      CCSF_SRC_ANALOG = 2'h0,
      CCSF_SRC_CASCADE = 2'h1,
      CCSF_SRC_RATIO = 2'h2
   } ccsf_src_t;
   // Parameter editor, one-hot
   typedef enum logic [3:0] {
      CCSF_ED_MON = 4'h1,
      CCSF_ED_BIAS = 4'h2,
      CCSF_ED_FILT = 4'h4,
      CCSF_ED_RATIO = 4'h8
   } ccsf_ed_t;
   // Link word from a peer
   typedef struct packed {
      logic valid;
      logic [4:0] src;
      logic [15:0] word;
   } ccsf_link_t;
   typedef struct packed {
      ccsf_ed_t ed;
      logic [15:0] pend;
      logic pend_valid;
      logic [31:0] ed_timer;
      ccsf_src_t in_type;
      logic [4:0] mchan;
      logic [15:0] bias;
      logic [15:0] filt;
      logic [15:0] ratio;
      logic [15:0] lo;
      logic [15:0] hi;
      logic [15:0] src_x;
      logic [15:0] filt_y;
      logic [31:0] tick;
      logic [15:0] sv;
      logic sv_upd;
      logic act;
      logic ack;
      logic [31:0] dat;
   } ccsf_state_t;
   localparam ccsf_state_t STATE_RST = '{
      ed: CCSF_ED_MON, pend: 16'h0000, pend_valid: 1'b0,
      ed_timer: 32'h0000_0000, in_type: CCSF_SRC_ANALOG, mchan: CHAN_RST,
      bias: 16'h0000, filt: FILT_OFF, ratio: RATIO_RST,
      lo: SCALE_LO_RST, hi: SCALE_HI_RST, src_x: 16'h0000,
      filt_y: 16'h0000, tick: 32'h0000_0000, sv: 16'h0000,
      sv_upd: 1'b0, act: 1'b0, ack: 1'b0, dat: 32'h0000_0000};
endpackage : ccsf_pkg
`default_nettype wire

// file: ccsf_top.sv
// Cascade setpoint follower: link intake, scaling, filter, editor, bus
//
// Behaviour
// - Refresh remote set value per accepted link word
// - Link sources need second port; analog ignored
// - Link addresses cover at most 32 nodes
// - Cascade slave takes master manipulated output
// - Type codes: 0 analog, 1 cascade, 2 ratio
// - Master channel 0 to 31 selects source
// - Type and channel writable only in stop
// - Follow link only in remote mode
// - Bias within plus/minus input span, default 0
// - Filter 0.1 to 100.0 s or off
// - Ratio 0.001 to 9.999, default 1.000
// - Map span, multiply ratio, add bias
// - Unconfirmed edit discarded after one minute
// - One parameter set serves every source type
// - Master in remote mode may set parameters
// - Confirm commits, steps bias, filter, ratio
// - Master to slave lag up to 70 ms per node
//
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`default_nettype none
module ccsf_top #(
   parameter int unsigned EDIT_TIMEOUT_CYC = ccsf_pkg::EDIT_TIMEOUT_CYC,
   parameter int unsigned FILT_TICK_CYC = ccsf_pkg::FILT_TICK_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Intercontroller link
   input wire ccsf_pkg::ccsf_link_t link_i,
   // Controller state
   input wire logic stop_mode_i,
   input wire logic remote_mode_i,
   input wire logic second_comm_port_ok_i,
   input wire logic [15:0] local_set_value_i,
   input wire logic [15:0] remote_setting_i,
   // Results
   output logic [15:0] set_value_o,
   output logic sv_update_o,
   output logic link_follow_o
);
   ccsf_pkg::ccsf_state_t s;
   ccsf_pkg::ccsf_state_t n;
   logic req;
   logic wr;
   logic [31:0] rdata;
   logic [31:0] cfg_w;
   logic [31:0] scl_w;
   logic link_hit;
   logic signed [31:0] span;
   logic signed [31:0] pv;
   logic signed [31:0] mapped;
   logic signed [31:0] step;
   logic signed [31:0] calc;
   logic p_ok;

   function automatic logic [31:0] merge(input logic [31:0] o,
         input logic [31:0] d, input logic [3:0] sel);
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            o[8*i +: 8] = d[8*i +: 8];
         end
      end
      return o;
   endfunction : merge

   function automatic logic in_rng(input logic signed [31:0] v,
         input logic signed [31:0] lo, input logic signed [31:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction : in_rng

   // Registers read back
   always_comb begin
      case (wb_adr_i)
         ccsf_pkg::OFS_CONFIG: rdata = {19'h0_0000, s.mchan, 6'h00,
            s.in_type};
         ccsf_pkg::OFS_EDIT: rdata = {11'h000, s.pend_valid, s.ed,
            s.pend};
         ccsf_pkg::OFS_BIAS: rdata = {16'h0000, s.bias};
         ccsf_pkg::OFS_FILTER: rdata = {16'h0000, s.filt};
         ccsf_pkg::OFS_RATIO: rdata = {16'h0000, s.ratio};
         ccsf_pkg::OFS_SCALE: rdata = {s.hi, s.lo};
         ccsf_pkg::OFS_STATUS: rdata = {14'h0000, s.act, remote_mode_i,
            s.sv};
         default: rdata = 32'h0000_0000;
      endcase
   end

   always_comb begin
      n = s;
      n.sv_upd = 1'b0;
      req = wb_cyc_i & wb_stb_i;
      // Write lands on the edge where ack is seen high
      wr = req & s.ack & wb_we_i;
      n.ack = req & ~s.ack;
      n.dat = n.ack ? rdata : 32'h0000_0000;
      cfg_w = merge({19'h0_0000, s.mchan, 6'h00, s.in_type}, wb_dat_i,
         wb_sel_i);
      scl_w = merge({s.hi, s.lo}, wb_dat_i, wb_sel_i);
      span = 32'(signed'(s.hi)) - 32'(signed'(s.lo));
      pv = 32'(signed'(s.pend));

      // Type and channel frozen while control runs; scale writable in any mode
      if (wr && wb_adr_i == ccsf_pkg::OFS_CONFIG && stop_mode_i) begin
         if (cfg_w[ccsf_pkg::CFG_TYPE_LSB +: 2] <= 2'h2) begin
            n.in_type = ccsf_pkg::ccsf_src_t'(
               cfg_w[ccsf_pkg::CFG_TYPE_LSB +: 2]);
         end
         n.mchan = cfg_w[ccsf_pkg::CFG_CHAN_LSB +: 5];
      end
      if (wr && wb_adr_i == ccsf_pkg::OFS_SCALE) begin
         n.lo = scl_w[15:0];
         n.hi = scl_w[ccsf_pkg::SCALE_HI_LSB +: 16];
      end

      // Editor; open in any mode so a remote master can tune too
      if (s.pend_valid) begin
         n.ed_timer = s.ed_timer + 32'h0000_0001;
         if (s.ed_timer >= EDIT_TIMEOUT_CYC - 1) begin
            n.pend_valid = 1'b0;
            n.ed_timer = 32'h0000_0000;
            n.ed = ccsf_pkg::CCSF_ED_MON;
         end
      end
      if (wr && wb_adr_i == ccsf_pkg::OFS_EDIT) begin
         n.pend = 16'(merge({16'h0000, s.pend}, wb_dat_i, wb_sel_i));
         n.pend_valid = 1'b1;
         n.ed_timer = 32'h0000_0000;
         if (s.ed == ccsf_pkg::CCSF_ED_MON) begin
            n.ed = ccsf_pkg::CCSF_ED_BIAS;
         end
      end
      // Confirm beats a timeout in the same cycle
      if (wr && wb_adr_i == ccsf_pkg::OFS_CONFIRM) begin
         n.pend_valid = 1'b0;
         n.ed_timer = 32'h0000_0000;
         case (s.ed)
            ccsf_pkg::CCSF_ED_BIAS: begin
               if (s.pend_valid && in_rng(pv, -span, span)) begin
                  n.bias = s.pend;
               end
               n.ed = ccsf_pkg::CCSF_ED_FILT;
            end
            ccsf_pkg::CCSF_ED_FILT: begin
               if (s.pend_valid && (s.pend == ccsf_pkg::FILT_OFF ||
                     (s.pend >= ccsf_pkg::FILT_MIN &&
                     s.pend <= ccsf_pkg::FILT_MAX))) begin
                  n.filt = s.pend;
               end
               n.ed = ccsf_pkg::CCSF_ED_RATIO;
            end
            ccsf_pkg::CCSF_ED_RATIO: begin
               if (s.pend_valid && s.pend >= ccsf_pkg::RATIO_MIN &&
                     s.pend <= ccsf_pkg::RATIO_MAX) begin
                  n.ratio = s.pend;
               end
               n.ed = ccsf_pkg::CCSF_ED_MON;
            end
            default: n.ed = ccsf_pkg::CCSF_ED_MON;
         endcase
      end

      // Source selection; a 5-bit address caps the link at 32 nodes
      p_ok = second_comm_port_ok_i;
      link_hit = link_i.valid && p_ok && link_i.src == s.mchan &&
         s.in_type != ccsf_pkg::CCSF_SRC_ANALOG;
      mapped = 32'(signed'(s.lo)) + ($signed(32'(link_i.word)) * span) /
         $signed(32'(ccsf_pkg::MV_FULL));
      case (s.in_type)
         ccsf_pkg::CCSF_SRC_ANALOG: n.src_x = remote_setting_i;
         ccsf_pkg::CCSF_SRC_CASCADE: begin
            if (link_hit) begin
               n.src_x = mapped[15:0];
            end
         end
         ccsf_pkg::CCSF_SRC_RATIO: begin
            if (link_hit) begin
               n.src_x = link_i.word;
            end
         end
         default: n.src_x = s.src_x;
      endcase

      // First-order lag, one step per 0.1 s tick
      n.tick = (s.tick >= FILT_TICK_CYC - 1) ? 32'h0000_0000 :
         s.tick + 32'h0000_0001;
      step = 32'(signed'(n.src_x)) - 32'(signed'(s.filt_y));
      if (s.filt == ccsf_pkg::FILT_OFF) begin
         n.filt_y = n.src_x;
      end else if (s.tick >= FILT_TICK_CYC - 1) begin
         // Signed divide, or a falling input would wrap the lag
         n.filt_y = 16'(32'(signed'(s.filt_y)) +
            step / $signed(32'(s.filt)));
      end

      // Ratio and bias, held within the input scale
      calc = (32'(signed'(n.filt_y)) * $signed(32'(s.ratio))) /
         $signed(32'(ccsf_pkg::FIXED_ONE)) + 32'(signed'(s.bias));
      if (calc > 32'(signed'(s.hi))) begin
         calc = 32'(signed'(s.hi));
      end
      if (calc < 32'(signed'(s.lo))) begin
         calc = 32'(signed'(s.lo));
      end
      n.act = remote_mode_i && p_ok &&
         s.in_type != ccsf_pkg::CCSF_SRC_ANALOG;
      n.sv = remote_mode_i ? calc[15:0] : local_set_value_i;
      // One cycle of our own on top of the link lag
      n.sv_upd = link_hit && remote_mode_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= ccsf_pkg::STATE_RST;
      end else begin
         s <= n;
      end
   end

   assign wb_dat_o = s.dat;
   assign wb_ack_o = s.ack;
   assign set_value_o = s.sv;
   assign sv_update_o = s.sv_upd;
   assign link_follow_o = s.act;

   AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
   AST_ACK_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered next cycle");
   AST_CFG_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
      (!stop_mode_i && wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
      wb_adr_i == ccsf_pkg::OFS_CONFIG) |=> $stable(s.in_type) &&
      $stable(s.mchan)) else $error("config changed while running");
   AST_TYPE_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
      s.in_type <= 2'h2) else $error("illegal input type code");
   AST_RATIO_RNG: assert property (@(posedge clk_i) disable iff (rst_i)
      s.ratio >= ccsf_pkg::RATIO_MIN && s.ratio <= ccsf_pkg::RATIO_MAX)
      else $error("ratio out of range");
   AST_FILT_RNG: assert property (@(posedge clk_i) disable iff (rst_i)
      s.filt <= ccsf_pkg::FILT_MAX) else $error("filter out of range");
   AST_LOCAL_SV: assert property (@(posedge clk_i) disable iff (rst_i)
      !remote_mode_i |=> set_value_o == $past(local_set_value_i))
      else $error("local mode not using local set value");
   AST_LINK_UPD: assert property (@(posedge clk_i) disable iff (rst_i)
      (link_i.valid && remote_mode_i && second_comm_port_ok_i &&
      link_i.src == s.mchan && s.in_type == ccsf_pkg::CCSF_SRC_CASCADE)
      |=> sv_update_o) else $error("master word not taken");
   AST_NO_PORT: assert property (@(posedge clk_i) disable iff (rst_i)
      !second_comm_port_ok_i |=> !sv_update_o && !link_follow_o)
      else $error("link followed without second port");
   AST_EDIT_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
      (s.pend_valid && s.ed_timer >= EDIT_TIMEOUT_CYC - 1 &&
      !(wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i))
      |=> !s.pend_valid && s.ed == ccsf_pkg::CCSF_ED_MON &&
      $stable(s.ratio)) else $error("stale edit not discarded");
endmodule : ccsf_top
`default_nettype wire

// file: ccsf_top_tb.sv
// Self-checking bench for the cascade setpoint follower
`default_nettype none
module ccsf_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, cyc, stb, we, stop, remote, port_ok, go, ack, upd, fol;
   logic busy;
   logic [7:0] adr, lag;
   logic [31:0] wdat, rdat, rd;
   logic [3:0] sel;
   logic [4:0] src;
   logic [15:0] word, lsv, rset, sv;
   ccsf_pkg::ccsf_link_t link;
   int fails = 0;
   int n_compared = 0;
   logic [31:0] rs = 32'h0000_0011;
   ccsf_top #(.EDIT_TIMEOUT_CYC(200), .FILT_TICK_CYC(10)) u_dut (
      .clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_dat_o(rd), .wb_ack_o(ack), .link_i(link), .stop_mode_i(stop),
      .remote_mode_i(remote), .second_comm_port_ok_i(port_ok),
      .local_set_value_i(lsv), .remote_setting_i(rset),
      .set_value_o(sv), .sv_update_o(upd), .link_follow_o(fol));
   ccsf_peer u_peer (
      .clk_i(clk), .rst_i(rst), .go_i(go), .src_i(src), .word_i(word),
      .lag_i(lag), .link_o(link), .busy_o(busy));
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : xs
   function automatic logic [15:0] exp_sv(input int t, input int w,
         input int lo, input int hi, input int r, input int b);
      int x;
      int s;
      x = (t == 2) ? w : lo + w * (hi - lo) / 1000;
      s = x * r / 1000 + b;
      if (s < lo) s = lo;
      if (s > hi) s = hi;
      return s[15:0];
   endfunction : exp_sv
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rdat = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         fails++;
         $display("[ERR] %0t bus answer missing", $time);
         finish_test();
      end
   endtask : wb
   task automatic rc(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(rdat & m, e);
   endtask : rc
   // Lag is random so the block sees prompt and slow peers alike
   task automatic send(input logic [4:0] s, input logic [15:0] w,
         input logic e, input logic [15:0] v);
      int n;
      @(posedge clk);
      go <= 1'b1;
      src <= s;
      word <= w;
      lag <= 8'(xs() % 8);
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (upd !== 1'b1 && n < 30);
      chk({31'h0, upd === 1'b1}, {31'h0, e});
      if (e) chk({16'h0, sv}, {16'h0, v});
   endtask : send
   task automatic burst(input int t, input int lo, input int hi,
         input int r, input int b, input int m);
      int w;
      for (int i = 0; i < 6; i++) begin
         w = (i == 0) ? 0 : (i == 1) ? m : int'(xs() % 1001) * m / 1000;
         send(5'h05, w[15:0], 1'b1, exp_sv(t, w, lo, hi, r, b));
      end
   endtask : burst
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      {rst, cyc, stb, we, stop, remote, port_ok, go} = 8'h80;
      {adr, lag, src} = 21'h0;
      {wdat, word, lsv, rset} = 80'h0;
      sel = 4'hF;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rc(ccsf_pkg::OFS_CONFIG, 32'hFFFF_FFFF, 32'h0000_0000);
      rc(ccsf_pkg::OFS_BIAS, 32'h0000_FFFF, 32'h0000_0000);
      rc(ccsf_pkg::OFS_FILTER, 32'h0000_FFFF, 32'h0000_0000);
      rc(ccsf_pkg::OFS_RATIO, 32'h0000_FFFF, 32'h0000_03E8);
      rc(ccsf_pkg::OFS_SCALE, 32'hFFFF_FFFF, 32'h03E8_0000);
      rc(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
      $display("test reset done");
      wb(1'b1, ccsf_pkg::OFS_CONFIG, 32'h0000_0501);
      rc(ccsf_pkg::OFS_CONFIG, 32'hFFFF_FFFF, 32'h0000_0000);
      stop <= 1'b1;
      wb(1'b1, ccsf_pkg::OFS_CONFIG, 32'h0000_0501);
      wb(1'b1, ccsf_pkg::OFS_CONFIG, 32'h0000_0503);
      rc(ccsf_pkg::OFS_CONFIG, 32'hFFFF_FFFF, 32'h0000_0501);
      stop <= 1'b0;
      remote <= 1'b1;
      port_ok <= 1'b1;
      burst(1, 0, 1000, 1000, 0, 1000);
      chk({31'h0, fol}, 32'h0000_0001);
      rc(ccsf_pkg::OFS_STATUS, 32'h0003_0000, 32'h0003_0000);
      send(5'h06, 16'h01F4, 1'b0, 16'h0000);
      port_ok <= 1'b0;
      send(5'h05, 16'h01F4, 1'b0, 16'h0000);
      port_ok <= 1'b1;
      remote <= 1'b0;
      lsv <= 16'h04D2;
      repeat (3) @(posedge clk);
      chk({16'h0, sv}, 32'h0000_04D2);
      chk({31'h0, fol}, 32'h0000_0000);
      remote <= 1'b1;
      $display("test follow done");
      wb(1'b1, ccsf_pkg::OFS_EDIT, 32'h0000_FFEC);
      rc(ccsf_pkg::OFS_EDIT, 32'h001F_0000, 32'h0012_0000);
      wb(1'b1, ccsf_pkg::OFS_CONFIRM, 32'h0000_0000);
      rc(ccsf_pkg::OFS_BIAS, 32'h0000_FFFF, 32'h0000_FFEC);
      rc(ccsf_pkg::OFS_EDIT, 32'h000F_0000, 32'h0004_0000);
      wb(1'b1, ccsf_pkg::OFS_CONFIRM, 32'h0000_0000);
      rc(ccsf_pkg::OFS_FILTER, 32'h0000_FFFF, 32'h0000_0000);
      wb(1'b1, ccsf_pkg::OFS_EDIT, 32'h0000_01F4);
      wb(1'b1, ccsf_pkg::OFS_CONFIRM, 32'h0000_0000);
      rc(ccsf_pkg::OFS_RATIO, 32'h0000_FFFF, 32'h0000_01F4);
      rc(ccsf_pkg::OFS_EDIT, 32'h000F_0000, 32'h0001_0000);
      wb(1'b1, ccsf_pkg::OFS_SCALE, 32'h01F4_0064);
      burst(1, 100, 500, 500, -20, 1000);
      stop <= 1'b1;
      wb(1'b1, ccsf_pkg::OFS_CONFIG, 32'h0000_0502);
      stop <= 1'b0;
      burst(2, 100, 500, 500, -20, 500);
      stop <= 1'b1;
      wb(1'b1, ccsf_pkg::OFS_CONFIG, 32'h0000_0500);
      rset <= 16'h012C;
      repeat (4) @(posedge clk);
      chk({16'h0, sv}, 32'h0000_0082);
      chk({31'h0, fol}, 32'h0000_0000);
      send(5'h05, 16'h02BC, 1'b0, 16'h0000);
      $display("test params done");
      wb(1'b1, ccsf_pkg::OFS_EDIT, 32'h0000_0007);
      repeat (210) @(posedge clk);
      rc(ccsf_pkg::OFS_EDIT, 32'h000F_0000, 32'h0001_0000);
      rc(ccsf_pkg::OFS_BIAS, 32'h0000_FFFF, 32'h0000_FFEC);
      $display("test timeout done");
      wb(1'b1, ccsf_pkg::OFS_EDIT, 32'h0000_FFEC);
      wb(1'b1, ccsf_pkg::OFS_CONFIRM, 32'h0000_0000);
      wb(1'b1, ccsf_pkg::OFS_EDIT, 32'h0000_03E8);
      wb(1'b1, ccsf_pkg::OFS_CONFIRM, 32'h0000_0000);
      rc(ccsf_pkg::OFS_FILTER, 32'h0000_FFFF, 32'h0000_03E8);
      wb(1'b1, ccsf_pkg::OFS_EDIT, 32'h0000_2710);
      wb(1'b1, ccsf_pkg::OFS_CONFIRM, 32'h0000_0000);
      rc(ccsf_pkg::OFS_RATIO, 32'h0000_FFFF, 32'h0000_01F4);
      $display("test ranges done");
      // Slow lag: a small drop moves nothing, a big rise creeps
      rset <= 16'h0064;
      repeat (40) @(posedge clk);
      chk({16'h0, sv}, 32'h0000_0082);
      rset <= 16'h0960;
      repeat (40) @(posedge clk);
      chk({31'h0, sv > 16'h0082 && sv < 16'h008C}, 32'h0000_0001);
      $display("test filter done");
      finish_test();
   end
endmodule : ccsf_top_tb
`default_nettype wire
